/* design/fan_zone_pkg.sv */
// Purpose: constants and helpers shared by the auto fan zone logic
// Assumes: 25 MHz system clock, 8-bit signed temperatures
// Notes: spans are held at six times their value to stay integral
package fan_zone_pkg;

    // ==========================================================
    // clock and timebase
    localparam int CLK_HZ = 25_000_000;
    localparam int MS_PER_S = 1000;
    localparam int MS_CYCLES_DEF = CLK_HZ / MS_PER_S;
    localparam int NUM_ZONES = 3;
    localparam int NUM_REGS = 11;

    // ==========================================================
    // register offsets
    localparam logic [7:0] OFFMIN_ZONE1_SMOOTHING = 8'h62;
    localparam logic [7:0] ZONE2_ZONE3_SMOOTHING = 8'h63;
    localparam logic [7:0] FAN1_MIN_DUTY = 8'h64;
    localparam logic [7:0] FAN2_MIN_DUTY = 8'h65;
    localparam logic [7:0] FAN3_MIN_DUTY = 8'h66;
    localparam logic [7:0] ZONE1_FAN_ON_LIMIT = 8'h67;
    localparam logic [7:0] ZONE2_FAN_ON_LIMIT = 8'h68;
    localparam logic [7:0] ZONE3_FAN_ON_LIMIT = 8'h69;
    localparam logic [7:0] ZONE1_EMERGENCY_LIMIT = 8'h6a;
    localparam logic [7:0] ZONE2_EMERGENCY_LIMIT = 8'h6b;
    localparam logic [7:0] ZONE3_EMERGENCY_LIMIT = 8'h6c;
    localparam logic [7:0] REG_BASE = OFFMIN_ZONE1_SMOOTHING;
    localparam logic [7:0] REG_LAST = ZONE3_EMERGENCY_LIMIT;

    // index of each group in the register array
    localparam logic [3:0] IDX_SMOOTH1 = 4'h0;
    localparam logic [3:0] IDX_SMOOTH23 = 4'h1;
    localparam logic [3:0] IDX_MIN_DUTY = 4'h2;
    localparam logic [3:0] IDX_FAN_LIMIT = 4'h5;
    localparam logic [3:0] IDX_EMERG = 4'h8;

    // ==========================================================
    // reset values
    localparam logic [7:0] RST_SMOOTH = 8'h00;
    localparam logic [7:0] RST_MIN_DUTY = 8'h80;
    localparam logic [7:0] RST_FAN_LIMIT = 8'h5a;
    localparam logic [7:0] RST_EMERG = 8'h64;
    localparam logic [3:0] RST_SPAN = 4'hc;
    localparam logic [NUM_REGS-1:0][7:0] REG_RESET = {{3{RST_EMERG}}, {3{RST_FAN_LIMIT}},
                                                      {3{RST_MIN_DUTY}}, {2{RST_SMOOTH}}};

    // ==========================================================
    // field layout
    localparam logic [7:0] SMOOTH1_RW_MASK = 8'hef;
    localparam int HOLD_LSB = 5;
    localparam int Z1_EN_BIT = 3;
    localparam int Z1_WIN_LSB = 0;
    localparam int Z2_EN_BIT = 7;
    localparam int Z2_WIN_LSB = 4;
    localparam int Z3_EN_BIT = 3;
    localparam int Z3_WIN_LSB = 0;
    localparam logic [7:0] EMERG_DISABLED = 8'h80;
    localparam logic [7:0] FULL_DUTY = 8'hff;
    localparam logic [7:0] ZERO_DUTY = 8'h00;

    // span in degrees times six: 2, 2.5, 3.33 ... 53.33, 80
    localparam logic [10:0] SPAN_SCALE = 11'h006;
    localparam logic [8:0] SPAN_X6 [16] = '{9'h00c, 9'h00f, 9'h014, 9'h018, 9'h01e, 9'h028,
                                          9'h030, 9'h03c, 9'h050, 9'h060, 9'h078, 9'h0a0,
                                          9'h0c0, 9'h0f0, 9'h140, 9'h1e0};

    // smoothing windows in ms, the average moves every window/16
    localparam int WIN_MS [8] = '{35000, 17600, 11800, 7000, 4400, 3000, 1600, 800};
    localparam int EMA_SHIFT = 4;
    localparam int EMA_TAPS = 1 << EMA_SHIFT;

    function automatic logic [11:0] win_step_ms(input logic [2:0] sel);
        return 12'(WIN_MS[sel] / EMA_TAPS);
    endfunction

    function automatic logic signed [8:0] temp_gap(input logic [7:0] t, input logic [7:0] l);
        return $signed({t[7], t}) - $signed({l[7], l});
    endfunction

    function automatic logic sgt(input logic [7:0] a, input logic [7:0] b);
        return $signed(a) > $signed(b);
    endfunction

endpackage

/* design/fan_zone_if.sv */
// Purpose: per-zone link between control, smoother and duty ramp
// Assumes: one instance per zone, zone n drives fan n
// Notes: none
`timescale 1ns/1ps
interface fan_zone_if;
    logic [7:0] raw_temp;
    logic smooth_en;
    logic [2:0] smooth_window_sel;
    logic [7:0] temp;
    logic [7:0] fan_limit;
    logic [7:0] min_duty;
    logic below_limit_hold;
    logic [3:0] ramp_span_sel;
    logic [7:0] duty;

    modport ctrl (output raw_temp, smooth_en, smooth_window_sel, fan_limit, min_duty,
                  below_limit_hold, ramp_span_sel, input temp, duty);
    modport smooth (input raw_temp, smooth_en, smooth_window_sel, output temp);
    modport ramp (input temp, fan_limit, min_duty, below_limit_hold, ramp_span_sel, output duty);
endinterface

/* design/zone_smoother.sv */
// Purpose: spike smoothing of one zone temperature for fan control
// Assumes: ms_tick is a one-cycle pulse once per millisecond
// Notes: output is registered, bypass follows raw one cycle later
`timescale 1ns/1ps
module zone_smoother import fan_zone_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // timebase
    input wire logic ms_tick,
    // zone link
    fan_zone_if.smooth zi
);

    typedef struct packed {
        logic [15:0] acc;
        logic [11:0] cnt;
        logic [7:0] temp;
    } smooth_s;

    smooth_s q;
    smooth_s d;

    // ==========================================================
    // exponential average, 16 steps per window
    always_comb begin
        logic signed [16:0] diff;
        logic signed [16:0] step;
        diff = $signed({zi.raw_temp[7], zi.raw_temp, 8'h00}) - $signed({q.acc[15], q.acc});
        step = diff >>> EMA_SHIFT;
        // a minimum step so the average converges exactly
        if (step == 17'sd0 && diff != 17'sd0) begin
            step = diff[16] ? -17'sd1 : 17'sd1;
        end
        d = q;
        if (ce) begin
            if (!zi.smooth_en) begin
                d.acc = {zi.raw_temp, 8'h00};
                d.cnt = 12'h000;
            end else if (ms_tick) begin
                if (q.cnt >= win_step_ms(zi.smooth_window_sel) - 12'h001) begin
                    d.cnt = 12'h000;
                    d.acc = q.acc + 16'(step);
                end else begin
                    d.cnt = q.cnt + 12'h001;
                end
            end
            d.temp = d.acc[15:8];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // raw reading is only read here, never replaced
    assign zi.temp = q.temp;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_SMOOTH_BYPASS: assert property ((ce && !zi.smooth_en) |=> zi.temp == $past(zi.raw_temp))
        else $error("bypassed zone does not follow raw temperature");
    AST_SMOOTH_SLOW: assert property ((ce && zi.smooth_en && !ms_tick) |=> $stable(q.acc))
        else $error("smoothed value moved without a timebase tick");

    COV_SMOOTH_STEP: cover property (ce && zi.smooth_en && ms_tick ##1 $changed(q.acc));

endmodule

/* design/duty_ramp.sv */
// Purpose: linear duty ramp from minimum duty to full over the span
// Assumes: temperatures and limits are signed degrees
// Notes: purely combinational, registered by the caller
`timescale 1ns/1ps
module duty_ramp import fan_zone_pkg::*; (
    // zone link
    fan_zone_if.ramp zi
);

    logic [7:0] duty_c;

    always_comb begin
        logic signed [8:0] gap;
        logic [10:0] scaled;
        logic [10:0] span;
        logic [18:0] prod;
        gap = temp_gap(zi.temp, zi.fan_limit);
        scaled = {3'b000, gap[7:0]} * SPAN_SCALE;
        span = {2'b00, SPAN_X6[zi.ramp_span_sel]};
        prod = 19'h00000;
        if (gap < 9'sd0) begin
            // below the limit: off or held at minimum
            duty_c = zi.below_limit_hold ? zi.min_duty : ZERO_DUTY;
        end else if (scaled >= span) begin
            duty_c = FULL_DUTY;
        end else begin
            // divider is small; the span is one of sixteen constants
            prod = {3'b000, FULL_DUTY - zi.min_duty} * {8'h00, scaled};
            duty_c = zi.min_duty + 8'(prod / {8'h00, span});
        end
    end

    assign zi.duty = duty_c;

endmodule

/* design/auto_fan_zone_control.sv */
// Purpose: register file and automatic duty control for three fan zones
// Assumes: serial front end delivers byte writes and reads on clk
// Assumes: temperatures, lock, start and mode come from clk-domain logic
// Notes: fan n is driven by zone n
//
// Functional notes
// - ramp span code 0..15 selects 2 to 80 degrees above the limit
// - with the lock bit set, writes to these registers are dropped
// - while start is clear, control uses reset values, storage stays writable
// - below the limit, hold bit picks zero duty or minimum duty
// - smoothing feeds fan control only, raw readings stay unsmoothed
// - per-zone smoothing enable and 3-bit window in registers 62h/63h
// - window codes map to 35 down to 0.8 seconds
// - minimum duty register gives duty as value over 255
// - at the limit the fan runs at minimum, above it ramps up
// - limits are signed two's complement degrees
// - variant one: any zone over its emergency limit forces all fans full
// - emergency limit of 80h disables the override for that zone
// - variant two: only the fan of the hot zone goes full
// - duty rises linearly to full at limit plus span, full beyond
// - zone 1 remote one, zone 2 internal, zone 3 remote two
`timescale 1ns/1ps
module auto_fan_zone_control import fan_zone_pkg::*; #(
    parameter int MS_CYCLES = MS_CYCLES_DEF,
    parameter bit ALL_FANS_ON_ABS = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // register access
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // global control
    input wire logic cfg_lock,
    input wire logic cfg_start,
    input wire logic auto_mode,
    input wire logic [2:0][3:0] ramp_span_sel,
    // temperatures
    input wire logic [7:0] temp_remote1,
    input wire logic [7:0] temp_internal,
    input wire logic [7:0] temp_remote2,
    // fan drive
    output logic [2:0][7:0] pwm_duty,
    output logic [2:0] fan_forced
);

    typedef struct packed {
        logic [NUM_REGS-1:0][7:0] regs;
        logic [15:0] ms_cnt;
        logic ms_tick;
        logic [7:0] rdata;
        logic [2:0][7:0] duty;
        logic [2:0] forced;
    } ctrl_s;

    ctrl_s q;
    ctrl_s d;

    // ==========================================================
    // effective configuration
    logic [NUM_REGS-1:0][7:0] eff;
    logic [2:0][7:0] raw;
    logic [2:0][7:0] smooth_t;
    logic [2:0][7:0] ramp_duty;
    logic [2:0] over;
    logic [2:0] force_full;
    logic [2:0] hold;
    logic [2:0] sm_en;
    logic [2:0][2:0] win;
    logic [2:0][3:0] span_e;
    logic mapped;
    logic [3:0] idx;
    logic [7:0] wmask;

    // stored values are kept, but control sees defaults until start
    assign eff = cfg_start ? q.regs : REG_RESET;
    assign span_e = cfg_start ? ramp_span_sel : {3{RST_SPAN}};

    assign raw[0] = temp_remote1;
    assign raw[1] = temp_internal;
    assign raw[2] = temp_remote2;

    assign sm_en[0] = eff[IDX_SMOOTH1][Z1_EN_BIT];
    assign sm_en[1] = eff[IDX_SMOOTH23][Z2_EN_BIT];
    assign sm_en[2] = eff[IDX_SMOOTH23][Z3_EN_BIT];
    assign win[0] = eff[IDX_SMOOTH1][Z1_WIN_LSB +: 3];
    assign win[1] = eff[IDX_SMOOTH23][Z2_WIN_LSB +: 3];
    assign win[2] = eff[IDX_SMOOTH23][Z3_WIN_LSB +: 3];
    assign hold = eff[IDX_SMOOTH1][HOLD_LSB +: 3];

    // ==========================================================
    // per-zone smoothing and ramp
    fan_zone_if zi [NUM_ZONES] ();

    for (genvar g = 0; g < NUM_ZONES; g++) begin : g_zone
        assign zi[g].raw_temp = raw[g];
        assign zi[g].smooth_en = sm_en[g];
        assign zi[g].smooth_window_sel = win[g];
        assign zi[g].fan_limit = eff[IDX_FAN_LIMIT + 4'(g)];
        assign zi[g].min_duty = eff[IDX_MIN_DUTY + 4'(g)];
        assign zi[g].below_limit_hold = hold[g];
        assign zi[g].ramp_span_sel = span_e[g];
        assign smooth_t[g] = zi[g].temp;
        assign ramp_duty[g] = zi[g].duty;

        zone_smoother u_smooth (
            .clk(clk),
            .rst_n(rst_n),
            .ce(ce),
            .ms_tick(q.ms_tick),
            .zi(zi[g])
        );

        duty_ramp u_ramp (
            .zi(zi[g])
        );

        // 80h is the most negative value, so compare alone can't disable it
        assign over[g] = (eff[IDX_EMERG + 4'(g)] != EMERG_DISABLED) &&
                         sgt(smooth_t[g], eff[IDX_EMERG + 4'(g)]);
        // variant picks all fans or only the fan of the hot zone
        assign force_full[g] = auto_mode && (ALL_FANS_ON_ABS ? |over : over[g]);
    end

    // ==========================================================
    // register decode
    assign mapped = (reg_addr >= REG_BASE) && (reg_addr <= REG_LAST);
    assign idx = 4'(reg_addr - REG_BASE);
    assign wmask = (idx == IDX_SMOOTH1) ? SMOOTH1_RW_MASK : 8'hff;

    // ==========================================================
    // next state
    always_comb begin
        d = q;
        if (ce) begin
            d.ms_tick = 1'b0;
            if (q.ms_cnt == 16'(MS_CYCLES - 1)) begin
                d.ms_cnt = 16'h0000;
                d.ms_tick = 1'b1;
            end else begin
                d.ms_cnt = q.ms_cnt + 16'h0001;
            end
            if (reg_wr && mapped && !cfg_lock) begin
                d.regs[idx] = reg_wdata & wmask;
            end
            if (reg_rd) begin
                d.rdata = mapped ? q.regs[idx] : 8'h00;
            end
            for (int f = 0; f < NUM_ZONES; f++) begin
                d.duty[f] = force_full[f] ? FULL_DUTY : ramp_duty[f];
            end
            d.forced = force_full;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{regs: REG_RESET, default: '0};
        end else begin
            q <= d;
        end
    end

    assign reg_rdata = q.rdata;
    assign pwm_duty = q.duty;
    assign fan_forced = q.forced;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic signed [8:0] gap0;
    assign gap0 = temp_gap(smooth_t[0], eff[IDX_FAN_LIMIT]);

    AST_LOCK_DROPS_WRITE: assert property ((ce && reg_wr && cfg_lock) |=> q.regs == $past(q.regs))
        else $error("locked register changed on write");
    AST_WRITE_STORES: assert property ((ce && reg_wr && !cfg_lock && reg_addr == FAN1_MIN_DUTY)
        |=> q.regs[IDX_MIN_DUTY] == $past(reg_wdata))
        else $error("unlocked write was not stored");
    AST_DEFAULT_OFF: assert property ((ce && !cfg_start && !auto_mode && sgt(RST_FAN_LIMIT, smooth_t[0]))
        |=> pwm_duty[0] == ZERO_DUTY)
        else $error("unstarted control did not use default limit and off");
    AST_BELOW_HOLD: assert property ((ce && !auto_mode && gap0 < 9'sd0 && hold[0])
        |=> pwm_duty[0] == $past(eff[IDX_MIN_DUTY]))
        else $error("held fan not at minimum below limit");
    AST_AT_LIMIT_MIN: assert property ((ce && !auto_mode && gap0 == 9'sd0)
        |=> pwm_duty[0] == $past(eff[IDX_MIN_DUTY]))
        else $error("fan not at minimum duty at the limit");
    AST_ABOVE_SPAN_FULL: assert property ((ce && !auto_mode && gap0 >= 9'sd80) |=> pwm_duty[0] == FULL_DUTY)
        else $error("fan not full above limit plus widest span");
    AST_EMERG_ALL: assert property ((ce && ALL_FANS_ON_ABS && auto_mode && |over)
        |=> pwm_duty == {3{FULL_DUTY}} && fan_forced == 3'h7)
        else $error("emergency did not force every fan full");
    AST_EMERG_ONE: assert property ((ce && !ALL_FANS_ON_ABS && auto_mode && over[1] && !over[0])
        |=> pwm_duty[1] == FULL_DUTY && !fan_forced[0])
        else $error("emergency forced the wrong fans");
    AST_EMERG_DISABLED: assert property ((ce && eff[IDX_EMERG] == EMERG_DISABLED && !ALL_FANS_ON_ABS)
        |=> !fan_forced[0])
        else $error("disabled emergency limit still forced a fan");
    AST_NO_FORCE_MANUAL: assert property ((ce && !auto_mode) |=> fan_forced == 3'h0)
        else $error("override active outside automatic mode");

    COV_EMERG: cover property (ce && auto_mode && |over ##1 |fan_forced);
    COV_LOCKED_WRITE: cover property (ce && reg_wr && mapped && cfg_lock);
    COV_RAMP_MID: cover property (ce && gap0 > 9'sd0 && pwm_duty[0] != FULL_DUTY);

endmodule

/* tb/fan_host_model.sv */
// Purpose: host side model driving the register byte port
// Assumes: one strobe cycle per access, changes 1 ns after the edge
// Notes: idle address and data are inverted so stale values are not trusted
`timescale 1ns/1ps
module fan_host_model (
    // clock
    input wire logic clk,
    // register port
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // ==========================================================
    // accesses
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    // read data is registered at the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask
endmodule

/* tb/tb_auto_fan_zone_control.sv */
// Purpose: self-checking bench for the auto fan zone control
// Assumes: both variants run side by side on shared inputs
// Notes: short millisecond count keeps smoothing runs brief
`timescale 1ns/1ps
module tb_auto_fan_zone_control import fan_zone_pkg::*;;
    typedef struct {logic [7:0] t, lim, mn; logic hold; logic [3:0] span; logic [7:0] exp;} row_s;
    logic clk, rst_n, ce, cfg_lock, cfg_start, auto_mode, wr, rd;
    logic [7:0] addr, wdata, rdata, t1, t2, t3, v;
    logic [2:0][3:0] span;
    logic [2:0][7:0] duty_a, duty_b;
    logic [2:0] forced_a, forced_b;
    int bad_count = 0;
    int cmp_count = 0;
    logic [7:0] rst_tab [11] = '{8'h00, 8'h00, 8'h80, 8'h80, 8'h80, 8'h5a, 8'h5a, 8'h5a, 8'h64, 8'h64, 8'h64};
    row_s rows [9] = '{'{8'h5a, 8'h5a, 8'h80, 1'b0, 4'hc, 8'h80}, '{8'h59, 8'h5a, 8'h80, 1'b0, 4'hc, 8'h00},
        '{8'h59, 8'h5a, 8'h80, 1'b1, 4'hc, 8'h80}, '{8'h3a, 8'h32, 8'h32, 1'b0, 4'h6, 8'hff},
        '{8'h36, 8'h32, 8'h32, 1'b0, 4'h6, 8'h98}, '{8'h28, 8'h00, 8'h80, 1'b0, 4'hf, 8'hbf},
        '{8'hcf, 8'hce, 8'h00, 1'b0, 4'h0, 8'h7f}, '{8'hff, 8'h00, 8'h00, 1'b0, 4'h0, 8'h00},
        '{8'h00, 8'h00, 8'hff, 1'b0, 4'h0, 8'hff}};

    // ==========================================================
    // design, both variants, and host model
    auto_fan_zone_control #(.MS_CYCLES(4), .ALL_FANS_ON_ABS(1'b1)) dut_u (.clk(clk), .rst_n(rst_n), .ce(ce),
        .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd), .reg_rdata(rdata), .cfg_lock(cfg_lock),
        .cfg_start(cfg_start), .auto_mode(auto_mode), .ramp_span_sel(span), .temp_remote1(t1),
        .temp_internal(t2), .temp_remote2(t3), .pwm_duty(duty_a), .fan_forced(forced_a));
    auto_fan_zone_control #(.MS_CYCLES(4), .ALL_FANS_ON_ABS(1'b0)) dut2_u (.clk(clk), .rst_n(rst_n), .ce(ce),
        .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd), .reg_rdata(), .cfg_lock(cfg_lock),
        .cfg_start(cfg_start), .auto_mode(auto_mode), .ramp_span_sel(span), .temp_remote1(t1),
        .temp_internal(t2), .temp_remote2(t3), .pwm_duty(duty_b), .fan_forced(forced_b));
    fan_host_model host_u (.clk(clk), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd),
        .reg_rdata(rdata));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ==========================================================
    // helpers
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk3(input logic [2:0] got, input logic [2:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic do_reset();
        rst_n = 1'b0;
        settle(20);
        rst_n = 1'b1;
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // watchdog, about three and a half times the expected run
    initial begin
        #(40 * 70000);
        bad_count++;
        stop_test();
    end

    // ==========================================================
    // main sequence
    initial begin
        {cfg_lock, cfg_start, auto_mode} = 3'b000;
        ce = 1'b1;
        {t1, t2, t3} = 24'h000000;
        span = '0;
        do_reset();
        for (int i = 0; i < 11; i++) begin
            host_u.rd(REG_BASE + 8'(i), v);
            chk8(v, rst_tab[i]);
        end
        $display("reset values done");
        // start clear: stored limit ignored, defaults drive the fan
        host_u.wr(8'h67, 8'h00);
        t1 = 8'h5a;
        settle(3);
        chk8(duty_a[0], 8'h80);
        host_u.rd(8'h67, v);
        chk8(v, 8'h00);
        cfg_start = 1'b1;
        settle(3);
        chk8(duty_a[0], 8'hff);
        $display("start default done");
        for (int i = 0; i < 9; i++) begin
            host_u.wr(8'h67, rows[i].lim);
            host_u.wr(8'h64, rows[i].mn);
            host_u.wr(8'h62, {2'b00, rows[i].hold, 5'h00});
            span[0] = rows[i].span;
            t1 = rows[i].t;
            settle(3);
            chk8(duty_a[0], rows[i].exp);
            chk8(duty_b[0], rows[i].exp);
        end
        $display("duty rows done");
        // every span code at two degrees over a zero limit
        host_u.wr(8'h64, 8'h00);
        t1 = 8'h02;
        for (int c = 0; c < 16; c++) begin
            span[0] = 4'(c);
            settle(2);
            chk8(duty_a[0], (SPAN_X6[c] <= 9'h00c) ? 8'hff : 8'(255 * 12 / SPAN_X6[c]));
        end
        $display("span codes done");
        cfg_lock = 1'b1;
        host_u.wr(8'h64, 8'h11);
        host_u.rd(8'h64, v);
        chk8(v, 8'h00);
        cfg_lock = 1'b0;
        host_u.wr(8'h62, 8'hff);
        host_u.rd(8'h62, v);
        chk8(v, 8'hef);
        host_u.rd(8'h70, v);
        chk8(v, 8'h00);
        $display("lock and map done");
        // emergency: zone 2 one degree over its limit
        auto_mode = 1'b1;
        t2 = 8'h65;
        settle(3);
        chk3(forced_a, 3'b111);
        chk8(duty_a[2], 8'hff);
        chk3(forced_b, 3'b010);
        chk8(duty_b[1], 8'hff);
        // enable low must freeze the forced outputs
        ce = 1'b0;
        t2 = 8'h64;
        settle(3);
        chk3(forced_a, 3'b111);
        ce = 1'b1;
        settle(3);
        chk3(forced_a, 3'b000);
        t2 = 8'h65;
        auto_mode = 1'b0;
        settle(3);
        chk3(forced_a, 3'b000);
        auto_mode = 1'b1;
        host_u.wr(8'h6b, 8'h80);
        settle(3);
        chk3(forced_a, 3'b000);
        chk3(forced_b, 3'b000);
        $display("emergency done");
        // smoothing on zone 1, shortest window; second reset mid-run
        do_reset();
        {t1, t2} = 16'h0000;
        // manual mode so the emergency override cannot mask the ramp
        auto_mode = 1'b0;
        host_u.wr(8'h67, 8'h00);
        host_u.wr(8'h64, 8'h00);
        span[0] = 4'hf;
        host_u.wr(8'h62, 8'h0f);
        settle(10);
        t1 = 8'h7f;
        settle(3);
        chk8({7'h00, duty_a[0] < 8'h20}, 8'h01);
        settle(20000);
        chk8(duty_a[0], 8'hff);
        $display("smoothing done");
        stop_test();
    end
endmodule
